// ===== design/ode_fsm.sv
// Overheat shutdown ideal-diode emulation state machine.
// How it works
// - A falling edge of the gate command in any shutdown state forces blanking and turns the switch off.
// - Blanking waits a fixed count independent of drain voltage and then moves on.
// - When the blanking count ends the machine enters the monitoring state.
// - The switch is off in the monitoring state, whether arriving from blanking or conducting.
// - A negative drain voltage seen while monitoring moves the machine to conducting.
// - Entering overheat shutdown starts the machine in the monitoring state.
// - In conducting the switch is on and current direction is watched.
// - First-quadrant current while conducting returns to monitoring with the switch off.
// - Without gate activity the machine moves only between monitoring and conducting.
// - There is no limit on how often conduction is re-entered.
// - The fault output is high while overheat shutdown is in effect.
`timescale 1ns/1ns
module ode_fsm
  import ode_pkg::*;
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rstn_i,
  // Controller side
  input  wire logic gate_cmd_i,
  input  wire logic overheat_shutdown_i,
  output logic      switch_on_o,
  output logic      fault_o,
  output logic      emulation_active_o,
  // Sense comparators
  input  wire logic drain_neg_i,
  input  wire logic current_first_quad_i
);

  ode_regs_t r_reg;
  ode_regs_t r_next;

  // ----------------------------------------------------------------------
  // Filtered inputs: gate and overheat change once stages two and three agree; drain and quadrant read low until they agree.
  // ----------------------------------------------------------------------
  logic gate_f;
  logic neg_f;
  logic fq_f;
  logic ot_f;

  always_comb
  begin
    gate_f = r_reg.gate_q;
    neg_f  = 1'b0;
    fq_f   = 1'b0;
    ot_f   = r_reg.fault;
    if (r_reg.sync.gate[1] == r_reg.sync.gate[2])
    begin
      gate_f = r_reg.sync.gate[2];
    end
    if (r_reg.sync.neg_drain[1] == r_reg.sync.neg_drain[2])
    begin
      neg_f = r_reg.sync.neg_drain[2];
    end
    if (r_reg.sync.first_quad[1] == r_reg.sync.first_quad[2])
    begin
      fq_f = r_reg.sync.first_quad[2];
    end
    if (r_reg.sync.overheat[1] == r_reg.sync.overheat[2])
    begin
      ot_f = r_reg.sync.overheat[2];
    end
  end

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.sync.gate       = {r_reg.sync.gate[1:0], gate_cmd_i};
    r_next.sync.neg_drain  = {r_reg.sync.neg_drain[1:0], drain_neg_i};
    r_next.sync.first_quad = {r_reg.sync.first_quad[1:0], current_first_quad_i};
    r_next.sync.overheat   = {r_reg.sync.overheat[1:0], overheat_shutdown_i};
    r_next.gate_q = gate_f;
    r_next.fault  = ot_f;

    if (!ot_f)
    begin
      r_next.state     = ODE_IDLE;
      r_next.blank_cnt = BLANK_CNT_RST;
    end
    else if (r_reg.gate_q && !gate_f)
    begin
      r_next.state     = ODE_BLANK;
      r_next.blank_cnt = BLANK_CNT_RST;
    end
    else
    begin
      unique case (r_reg.state)
        ODE_IDLE:
        begin
          r_next.state = ODE_MONITOR;
        end
        ODE_BLANK:
        begin
          // Drain voltage is ignored here so the machine cannot get stuck.
          if (r_reg.blank_cnt >= BLANK_CYCLES - 8'h01)
          begin
            r_next.state     = ODE_MONITOR;
            r_next.blank_cnt = BLANK_CNT_RST;
          end
          else
          begin
            r_next.blank_cnt = r_reg.blank_cnt + 8'h01;
          end
        end
        ODE_MONITOR:
        begin
          // No count of past conductions is kept, so re-entry is unlimited.
          if (neg_f)
          begin
            r_next.state = ODE_CONDUCT;
          end
        end
        ODE_CONDUCT:
        begin
          if (fq_f)
          begin
            r_next.state = ODE_MONITOR;
          end
        end
      endcase
    end

    // Switch on only while conducting in shutdown; off in blank and monitor.
    r_next.switch_on   = ot_f && (r_next.state == ODE_CONDUCT);
    r_next.emul_active = ot_f;
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      r_reg           <= '0;
      r_reg.state     <= ODE_IDLE;
      r_reg.blank_cnt <= BLANK_CNT_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign switch_on_o        = r_reg.switch_on;
  assign fault_o            = r_reg.fault;
  assign emulation_active_o = r_reg.emul_active;

endmodule : ode_fsm

// ===== design/ode_pkg.sv
// Package for the overheat diode emulation state machine.
package ode_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ   = 50_000_000;
  localparam int unsigned BLANK_TIME_NS = 200;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int unsigned BLANK_CYCLES_INT =
    (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CNT_W   = 8;
  localparam logic [BLANK_CNT_W-1:0] BLANK_CYCLES = BLANK_CYCLES_INT[BLANK_CNT_W-1:0];
  localparam logic [BLANK_CNT_W-1:0] BLANK_CNT_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ODE_IDLE,
    ODE_BLANK,
    ODE_MONITOR,
    ODE_CONDUCT
  } ode_state_t;

  // Synchroniser stages: bit 0 first, bit 2 last.
  typedef struct packed {
    logic [2:0] gate;
    logic [2:0] neg_drain;
    logic [2:0] first_quad;
    logic [2:0] overheat;
  } ode_sync_t;

  typedef struct packed {
    ode_sync_t             sync;
    logic                  gate_q;
    ode_state_t            state;
    logic [BLANK_CNT_W-1:0] blank_cnt;
    logic                  switch_on;
    logic                  fault;
    logic                  emul_active;
  } ode_regs_t;

endpackage : ode_pkg

// ===== dv/ode_fsm_asserts.sv
// Checker for the overheat diode emulation state machine.
`timescale 1ns/1ns
module ode_fsm_asserts
  import ode_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Observed pins
  input wire logic gate_cmd_i,
  input wire logic overheat_shutdown_i,
  input wire logic drain_neg_i,
  input wire logic current_first_quad_i,
  input wire logic switch_on_o,
  input wire logic fault_o,
  input wire logic emulation_active_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  fault_rise_a: assert property ($rose(overheat_shutdown_i) |-> ##[3:5] fault_o)
    else $error("fault late");
  off_idle_a: assert property (!fault_o |-> !switch_on_o)
    else $error("switch on outside shutdown");
  blank_off_a: assert property ($fell(gate_cmd_i) && fault_o |-> ##[2:5] !switch_on_o)
    else $error("switch on after gate fall");
  blank_hold_a: assert property ($fell(gate_cmd_i) && fault_o |-> ##5 !switch_on_o [*8])
    else $error("blanking too short");
  rise_cause_a: assert property ($rose(switch_on_o) |-> $past(drain_neg_i, 3))
    else $error("switch on without negative drain");
  quad_off_a: assert property ((current_first_quad_i && !drain_neg_i) [*6] |-> !switch_on_o)
    else $error("switch on in first quadrant");
  active_eq_a: assert property (emulation_active_o == fault_o)
    else $error("active differs from fault");
  entry_mon_a: assert property ($rose(fault_o) && drain_neg_i |-> ##[1:4] switch_on_o)
    else $error("entry not in monitoring");
endmodule : ode_fsm_asserts

bind ode_fsm ode_fsm_asserts u_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .gate_cmd_i(gate_cmd_i),
  .overheat_shutdown_i(overheat_shutdown_i), .drain_neg_i(drain_neg_i),
  .current_first_quad_i(current_first_quad_i), .switch_on_o(switch_on_o),
  .fault_o(fault_o), .emulation_active_o(emulation_active_o));

// ===== dv/ode_ctrl_model.sv
// Converter controller model that toggles the gate command on request.
`timescale 1ns/1ns
module ode_ctrl_model (
  input  wire logic clock_i,
  input  wire logic toggle_i,
  output logic      gate_o
);
  initial gate_o = 1'b1;
  always @(posedge clock_i) if (toggle_i) gate_o <= !gate_o;
endmodule : ode_ctrl_model

// ===== dv/ode_fsm_tb_top.sv
// Testbench for the overheat diode emulation state machine.
`timescale 1ns/1ns
module ode_fsm_tb_top;
  logic clock_i = 1'b0, rstn_i = 1'b0, tog = 1'b0, oh = 1'b0, dn = 1'b1, cq = 1'b0;
  logic gate, sw, ft, ea;
  int   n_errors = 0, cmp_count = 0, cyc_n = 0;
  always #10 clock_i = !clock_i;
  ode_ctrl_model u_ctrl (.clock_i(clock_i), .toggle_i(tog), .gate_o(gate));
  ode_fsm DUT (.clock_i(clock_i), .rstn_i(rstn_i), .gate_cmd_i(gate),
    .overheat_shutdown_i(oh), .switch_on_o(sw), .fault_o(ft),
    .emulation_active_o(ea), .drain_neg_i(dn), .current_first_quad_i(cq));
  task automatic chk(input logic s, input logic e);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: output mismatch", $time);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic t_entry();
    chk(sw, 1'b0);
    oh <= 1'b1;
    cyc(8);
    chk(ft, 1'b1);
    chk(ea, 1'b1);
    chk(sw, 1'b1);
  endtask : t_entry
  task automatic t_quad();
    repeat (3)
    begin
      dn <= 1'b0;
      cq <= 1'b1;
      cyc(6);
      chk(sw, 1'b0);
      cq <= 1'b0;
      dn <= 1'b1;
      cyc(6);
      chk(sw, 1'b1);
    end
  endtask : t_quad
  task automatic t_blank();
    tog <= 1'b1;
    cyc(1);
    tog <= 1'b0;
    cyc(6);
    chk(sw, 1'b0);
    cyc(6);
    chk(sw, 1'b0);
    cyc(6);
    chk(sw, 1'b1);
  endtask : t_blank
  task automatic t_exit();
    oh <= 1'b0;
    cyc(6);
    chk(ft, 1'b0);
    chk(ea, 1'b0);
    chk(sw, 1'b0);
  endtask : t_exit
  always @(posedge clock_i)
  begin
    cyc_n++;
    if (cyc_n == 2000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    cyc(6);
    rstn_i <= 1'b1;
    cyc(2);
    t_entry();
    t_quad();
    t_blank();
    t_exit();
    summarize();
  end
endmodule : ode_fsm_tb_top
